// *** logic/bsr_encoder.sv ***
// Encoder top: APB register file, scramble enable delay, byte assembly,
// block counting and serial insertion of the parity bytes.
// Assumes bitClockFall pulses for one ref_clk cycle at each falling edge
// of the internal bit clock, and user inputs are synchronous to ref_clk.
`timescale 1ns/1ps
`include "bsr_params.svh"
module bsr_encoder
   import bsr_pkg::*;
(
   // Clock, reset and clock enable.
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic clkEn,
   // Bit timing.
   input wire logic bitClockFall,
   // User data source.
   input wire logic txSerialIn,
   input wire logic dataAdvanceIn,
   input wire logic scrambleEnableIn,
   input wire logic rsEnableIn,
   // Encoded stream.
   output logic txSerialOut,
   output logic txOutValid,
   output logic parityInsertFlag,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [9:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   bsr_top_state_t s;
   bsr_top_state_t next_s;
   logic [7:0] idx;
   logic hit;
   logic [7:0] rdByte;
   logic apbSetup;
   logic apbAccess;
   logic scrEnEff;
   logic rsEff;
   logic advTick;
   logic [3:0] tEff;
   logic [4:0] nPar;
   logic [7:0] klenEff;
   logic [7:0] asmByte;
   logic scrOut;
   logic scrStep;
   logic feed;
   logic shiftOut;
   logic clear;
   logic parBit;
   logic [7:0] parTop;
   logic genBusy;

   // Out-of-range T and a zero K are pulled into range rather than left to
   // produce a generator of nonsense degree.
   always_comb begin
      tEff = s.ctrl[3:0];
      if (s.ctrl[3:0] == 4'h0) begin
         tEff = 4'h1;
      end else if (s.ctrl[3:0] > `BSR_T_MAX) begin
         tEff = `BSR_T_MAX;
      end
      klenEff = (s.klen == 8'h00) ? 8'h01 : s.klen;
   end
   assign nPar = {tEff, 1'b0};

   // Each function is either steered by its pin or held by a register bit.
   // The scramble pin goes through a register so it may rise together
   // with the bit clock before the first bit it is meant to cover.
   assign scrEnEff = s.path[`BSR_PATH_SCR_PIN] ? s.scrEnDly
                                               : s.path[`BSR_PATH_SCR_ON];
   assign rsEff = s.path[`BSR_PATH_RS_PIN] ? rsEnableIn
                                          : s.path[`BSR_PATH_RS_ON];
   assign advTick = bitClockFall && dataAdvanceIn;
   assign scrStep = advTick && scrEnEff && (s.phase == BSR_DATA);

   // Bit order of the byte handed to the parity engine.
   assign asmByte = s.order[`BSR_ORD_IN] ? {scrOut, s.asm[7:1]}
                                         : {s.asm[6:0], scrOut};
   // Parity bits leave most or least significant first.
   assign parBit = s.order[`BSR_ORD_PAR] ? parTop[s.bitCnt]
                                         : parTop[3'(3'h7 - s.bitCnt)];

   bsr_scrambler u_scr (
      .clk(ref_clk),
      .rst(rst),
      .ce(clkEn),
      .seed(s.seed),
      .taps(s.taps),
      .selfSync(s.ctrl[`BSR_CTRL_SELF_SYNC_SELECT]),
      .load(!scrEnEff),
      .step(scrStep),
      .din(txSerialIn),
      .dout(scrOut)
   );

   bsr_rs_parity u_rs (
      .clk(ref_clk),
      .rst(rst),
      .ce(clkEn),
      .rebuild(s.rebuild),
      .polySel(s.ctrl[`BSR_CTRL_PP]),
      .nPar(nPar),
      .clear(clear),
      .feed(feed),
      .dataByte(asmByte),
      .shiftOut(shiftOut),
      .parTop(parTop),
      .genBusy(genBusy)
   );

   // Address decode; only whole aligned words are mapped.
   assign idx = paddr[9:2];
   assign apbSetup = psel && !penable;
   assign apbAccess = psel && penable && s.pready;
   always_comb begin
      hit = (paddr[1:0] == 2'b00);
      rdByte = 8'h00;
      case (idx)
         `BSR_IDX_SEED_LO: rdByte = s.seed[7:0];
         `BSR_IDX_SEED_MID: rdByte = s.seed[15:8];
         `BSR_IDX_SEED_HI: rdByte = s.seed[23:16];
         `BSR_IDX_TAPS_LO: rdByte = s.taps[7:0];
         `BSR_IDX_TAPS_MID: rdByte = s.taps[15:8];
         `BSR_IDX_TAPS_HI: rdByte = s.taps[23:16];
         `BSR_IDX_CTRL: rdByte = s.ctrl;
         `BSR_IDX_KLEN: rdByte = s.klen;
         `BSR_IDX_ORDER: rdByte = s.order;
         `BSR_IDX_PATH: rdByte = {4'h0, s.path[3:0]};
         `BSR_IDX_STAT: rdByte = {4'h0, rsEff, scrEnEff, genBusy, s.flag};
         default: hit = 1'b0;
      endcase
   end

   // Register file, then the block and insertion sequencer.
   always_comb begin
      next_s = s;
      feed = 1'b0;
      shiftOut = 1'b0;
      clear = s.rebuild;
      next_s.scrEnDly = scrambleEnableIn;
      next_s.outValid = 1'b0;
      next_s.rebuild = 1'b0;
      next_s.pready = apbSetup;
      if (apbSetup) begin
         next_s.rdata = hit ? rdByte : 8'h00;
         next_s.slverr = !hit;
      end
      if (apbAccess && pwrite && !s.slverr) begin
         case (idx)
            `BSR_IDX_SEED_LO: next_s.seed[7:0] = pwdata[7:0];
            `BSR_IDX_SEED_MID: next_s.seed[15:8] = pwdata[7:0];
            `BSR_IDX_SEED_HI: next_s.seed[23:16] = pwdata[7:0];
            `BSR_IDX_TAPS_LO: next_s.taps[7:0] = pwdata[7:0];
            `BSR_IDX_TAPS_MID: next_s.taps[15:8] = pwdata[7:0];
            `BSR_IDX_TAPS_HI: next_s.taps[23:16] = pwdata[7:0];
            `BSR_IDX_CTRL: begin
               next_s.ctrl = pwdata[7:0];
               next_s.rebuild = 1'b1;
            end
            `BSR_IDX_KLEN: next_s.klen = pwdata[7:0];
            `BSR_IDX_ORDER: next_s.order = pwdata[7:0];
            `BSR_IDX_PATH: next_s.path = {4'h0, pwdata[3:0]};
            default: next_s.path = s.path;
         endcase
      end
      // With the encoder bypassed, block framing restarts from zero.
      if (!rsEff && s.phase == BSR_DATA) begin
         clear = 1'b1;
         next_s.bitCnt = 3'h0;
         next_s.byteCnt = 8'h00;
      end
      if (advTick) begin
         unique case (s.phase)
            BSR_DATA: begin
               next_s.outBit = scrOut;
               next_s.outValid = 1'b1;
               next_s.flag = 1'b0;
               // Bits that arrive during a generator rebuild pass through
               // unencoded; software should not reconfigure mid burst.
               if (rsEff && !genBusy) begin
                  next_s.asm = asmByte;
                  next_s.bitCnt = 3'(s.bitCnt + 3'h1);
                  if (s.bitCnt == 3'h7) begin
                     feed = 1'b1;
                     if (s.byteCnt == 8'(klenEff - 8'h01)) begin
                        next_s.phase = BSR_PARITY;
                        next_s.byteCnt = 8'h00;
                        next_s.parIdx = 5'h00;
                     end else begin
                        next_s.byteCnt = 8'(s.byteCnt + 8'h01);
                     end
                  end
               end
            end
            BSR_PARITY: begin
               // The serial input is not looked at in this phase.
               next_s.outBit = parBit;
               next_s.outValid = 1'b1;
               next_s.flag = 1'b1;
               next_s.bitCnt = 3'(s.bitCnt + 3'h1);
               if (s.bitCnt == 3'h7) begin
                  shiftOut = 1'b1;
                  if (s.parIdx == 5'(nPar - 5'h01)) begin
                     next_s.phase = BSR_DATA;
                     next_s.parIdx = 5'h00;
                     clear = 1'b1;
                  end else begin
                     next_s.parIdx = 5'(s.parIdx + 5'h01);
                  end
               end
            end
         endcase
      end
   end

   // All state in one register; a build starts right after reset.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s <= '0;
         s.ctrl <= `BSR_RST_CTRL;
         s.klen <= `BSR_RST_KLEN;
         s.path <= `BSR_RST_PATH;
         s.seed <= {3{`BSR_RST_BYTE}};
         s.taps <= {3{`BSR_RST_BYTE}};
         s.rebuild <= 1'b1;
      end else if (clkEn) begin
         s <= next_s;
      end
   end

   assign txSerialOut = s.outBit;
   assign txOutValid = s.outValid;
   assign parityInsertFlag = s.flag;
   assign prdata = {24'h000000, s.rdata};
   assign pready = s.pready;
   assign pslverr = s.slverr;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   sequence apbSetupSeq;
      psel && !penable && clkEn;
   endsequence
   sequence apbWriteCtrlSeq;
      psel && penable && pready && pwrite && !pslverr && clkEn
         && paddr == 10'h0D8;
   endsequence

   apb_ready_a: assert property (apbSetupSeq |=> pready)
      else $error("no ready after setup");
   ctrl_rebuild_a: assert property (apbWriteCtrlSeq |=> ##1
      s.ctrl == $past(pwdata[7:0], 2) && s.rebuild == 1'b0)
      else $error("control write not stored");
   freeze_a: assert property (!clkEn |=> $stable(s))
      else $error("state moved with clock enable low");
   no_advance_a: assert property ((clkEn && !advTick) |=> !txOutValid)
      else $error("output without data advance");
   systematic_a: assert property ((clkEn && advTick && s.phase == BSR_DATA)
      |=> txOutValid && txSerialOut == $past(scrOut) && !parityInsertFlag)
      else $error("data bit not passed through");
   parity_out_a: assert property ((clkEn && advTick && s.phase == BSR_PARITY)
      |=> txSerialOut == $past(parBit) && parityInsertFlag)
      else $error("parity bit or flag wrong");
   parity_entry_a: assert property ($rose(s.phase == BSR_PARITY)
      |-> s.bitCnt == 3'h0 && s.parIdx == 5'h00 && s.byteCnt == 8'h00)
      else $error("parity phase entered mid byte");
   parity_exit_a: assert property ((clkEn && advTick && s.phase == BSR_PARITY
      && s.bitCnt == 3'h7 && s.parIdx == 5'(nPar - 5'h01))
      |=> s.phase == BSR_DATA)
      else $error("insertion longer than 2T bytes");
   scr_hold_a: assert property ((clkEn && s.phase == BSR_PARITY) |-> !scrStep)
      else $error("scrambler stepped during parity");
endmodule

// *** logic/bsr_params.svh ***
// Constants of the burst scrambler and parity encoder: register indices,
// field positions, reset values and field arithmetic constants.
// Assumes it is included by bare name from every design file that needs it.
// Operation
// - Twenty-four presettable stages, any tap set.
// - Control bit 4 picks frame or self sync.
// - Disabled scrambler keeps reloading the seed.
// - One bit per bit-clock fall, both enables high.
// - Scramble enable is delayed inside the block.
// - Tap mask c24..c1 over three registers.
// - Seed s24..s1 over three registers.
// - Encoded data passes unchanged into parity math.
// - Parity bytes follow every K data bytes.
// - Serial input ignored while parity goes out.
// - Parity flag high for exactly 2T bytes.
// - GF(256) code, T in bits 3-0, 1..10.
// - Control bit 7 picks field polynomial.
// - Payload length K, 1 to 255-2T bytes.
// - Order bit 4 sets input byte bit order.
// - Order bit 5 sets parity bit order.
// - Generator roots start at 120 or zero.
// - Stages advance only with data advance high.
// - Pin control enables or bypasses each function.
`ifndef BSR_PARAMS_SVH
`define BSR_PARAMS_SVH
// Register indices; the byte address is four times the index.
`define BSR_IDX_SEED_LO 8'h30
`define BSR_IDX_SEED_MID 8'h31
`define BSR_IDX_SEED_HI 8'h32
`define BSR_IDX_TAPS_LO 8'h33
`define BSR_IDX_TAPS_MID 8'h34
`define BSR_IDX_TAPS_HI 8'h35
`define BSR_IDX_CTRL 8'h36
`define BSR_IDX_KLEN 8'h37
`define BSR_IDX_ORDER 8'h39
`define BSR_IDX_PATH 8'h3C
`define BSR_IDX_STAT 8'h3D
// Field positions.
`define BSR_CTRL_PP 7
`define BSR_CTRL_SELF_SYNC_SELECT 4
`define BSR_ORD_IN 4
`define BSR_ORD_PAR 5
`define BSR_PATH_SCR_PIN 0
`define BSR_PATH_SCR_ON 1
`define BSR_PATH_RS_PIN 2
`define BSR_PATH_RS_ON 3
// Reset values.
`define BSR_RST_BYTE 8'h00
`define BSR_RST_CTRL 8'h01
`define BSR_RST_KLEN 8'h01
`define BSR_RST_PATH 8'h05
// Field and code constants.
`define BSR_T_MAX 4'hA
`define BSR_ROOT_BASE 8'h78
`define BSR_POLY0_LOW 8'h1D
`define BSR_POLY1_LOW 8'h87
`define BSR_ALPHA 8'h02
`endif

// *** logic/bsr_pkg.sv ***
// Types shared by the scrambler, the parity engine and the encoder top.
// Assumes nothing beyond a SystemVerilog compiler.
package bsr_pkg;
   typedef enum logic [0:0] {BSR_DATA = 1'b0, BSR_PARITY = 1'b1} bsr_phase_t;
   typedef enum logic [1:0] {
      BSR_GIDLE = 2'b00,
      BSR_GPOW = 2'b01,
      BSR_GMUL = 2'b10
   } bsr_gen_t;
   typedef struct packed {
      logic [23:0] stages;
   } bsr_scr_state_t;
   typedef struct packed {
      bsr_gen_t gst;
      logic [7:0] cnt;
      logic [7:0] root;
      logic [20:0][7:0] gen;
      logic [19:0][7:0] par;
   } bsr_rs_state_t;
   typedef struct packed {
      logic [23:0] seed;
      logic [23:0] taps;
      logic [7:0] ctrl;
      logic [7:0] klen;
      logic [7:0] order;
      logic [7:0] path;
      logic scrEnDly;
      bsr_phase_t phase;
      logic [2:0] bitCnt;
      logic [7:0] byteCnt;
      logic [4:0] parIdx;
      logic [7:0] asm;
      logic outBit;
      logic outValid;
      logic flag;
      logic rebuild;
      logic pready;
      logic slverr;
      logic [7:0] rdata;
   } bsr_top_state_t;
endpackage

// *** logic/bsr_scrambler.sv ***
// Twenty-four stage programmable scrambler for one serial bit per step.
// Assumes step is a one-cycle pulse and ce freezes all state when low.
`timescale 1ns/1ps
`include "bsr_params.svh"
module bsr_scrambler
   import bsr_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Configuration.
   input wire logic [23:0] seed,
   input wire logic [23:0] taps,
   input wire logic selfSync,
   // Data.
   input wire logic load,
   input wire logic step,
   input wire logic din,
   output logic dout
);
   bsr_scr_state_t s;
   bsr_scr_state_t next_s;
   logic fb;

   // Feedback is the parity of the tapped stages; bit 0 is stage one.
   assign fb = ^(s.stages & taps);
   assign dout = load ? din : (din ^ fb);

   // A disabled scrambler reloads the seed every cycle, so a burst always
   // starts from the same state no matter how long the gap was.
   always_comb begin
      next_s = s;
      if (load) begin
         next_s.stages = seed;
      end else if (step) begin
         // Frame sync runs the generator on itself; self sync feeds back
         // the scrambled line bit so the far end can self-align.
         next_s.stages = {s.stages[22:0], selfSync ? dout : fb};
      end
   end

   // All state sits in one register, frozen by the clock enable.
   always_ff @(posedge clk) begin
      if (rst) begin
         s <= '0;
      end else if (ce) begin
         s <= next_s;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   seed_load_a: assert property ((load && ce) |=> s.stages == $past(seed))
      else $error("seed not copied while scrambler disabled");
   frame_fb_a: assert property ((step && ce && !load && !selfSync)
      |=> s.stages[0] == $past(fb) && s.stages[23:1] == $past(s.stages[22:0]))
      else $error("frame sync shift wrong");
   self_fb_a: assert property ((step && ce && !load && selfSync)
      |=> s.stages[0] == $past(dout))
      else $error("self sync feedback wrong");
endmodule

// *** logic/bsr_rs_parity.sv ***
// Byte-serial systematic parity engine over GF(256) with a generator that
// is rebuilt in hardware whenever the code parameters change.
// Assumes feed, shiftOut, clear and rebuild are one-cycle pulses.
`timescale 1ns/1ps
`include "bsr_params.svh"
module bsr_rs_parity
   import bsr_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Code parameters.
   input wire logic rebuild,
   input wire logic polySel,
   input wire logic [4:0] nPar,
   // Byte stream.
   input wire logic clear,
   input wire logic feed,
   input wire logic [7:0] dataByte,
   input wire logic shiftOut,
   output logic [7:0] parTop,
   output logic genBusy
);
   bsr_rs_state_t s;
   bsr_rs_state_t next_s;
   logic [4:0] topIdx;
   logic [7:0] fb;
   logic [7:0] rootNext;
   logic [20:0][7:0] genStep;
   logic [19:0][7:0] parStep;

   // Field product reduced by the selected primitive polynomial.
   function automatic logic [7:0] gfMul(input logic [7:0] a,
                                        input logic [7:0] b,
                                        input logic sel);
      logic [7:0] acc;
      logic [7:0] x;
      logic [7:0] low;
      acc = 8'h00;
      x = a;
      low = sel ? `BSR_POLY1_LOW : `BSR_POLY0_LOW;
      for (int i = 0; i < 8; i++) begin
         if (b[i]) begin
            acc = acc ^ x;
         end
         x = x[7] ? ({x[6:0], 1'b0} ^ low) : {x[6:0], 1'b0};
      end
      return acc;
   endfunction

   assign topIdx = 5'(nPar - 5'h01);
   assign fb = dataByte ^ s.par[topIdx];
   assign parTop = s.par[topIdx];
   assign genBusy = (s.gst != BSR_GIDLE);
   assign rootNext = gfMul(s.root, `BSR_ALPHA, polySel);

   // One multiplier per generator term and per parity term.
   for (genvar j = 0; j < 21; j++) begin : g_term
      if (j == 0) begin : g_low
         assign genStep[j] = gfMul(s.gen[j], s.root, polySel);
         assign parStep[j] = gfMul(fb, s.gen[j], polySel);
      end else if (j < 20) begin : g_mid
         assign genStep[j] = s.gen[j-1] ^ gfMul(s.gen[j], s.root, polySel);
         assign parStep[j] = s.par[j-1] ^ gfMul(fb, s.gen[j], polySel);
      end else begin : g_top
         assign genStep[j] = s.gen[j-1] ^ gfMul(s.gen[j], s.root, polySel);
      end
   end

   // Generator build: raise the root to its first power, then multiply
   // in one factor per cycle. A rebuild restarts at once, so a second
   // parameter write during a build is never lost.
   always_comb begin
      next_s = s;
      if (rebuild) begin
         next_s.gen = '0;
         next_s.gen[0] = 8'h01;
         next_s.root = 8'h01;
         if (polySel) begin
            next_s.gst = BSR_GMUL;
            next_s.cnt = {3'h0, nPar};
         end else begin
            next_s.gst = BSR_GPOW;
            next_s.cnt = `BSR_ROOT_BASE;
         end
      end else begin
         unique case (s.gst)
            BSR_GIDLE: begin
               next_s.gst = BSR_GIDLE;
            end
            BSR_GPOW: begin
               next_s.root = rootNext;
               next_s.cnt = 8'(s.cnt - 8'h01);
               if (s.cnt == 8'h01) begin
                  next_s.gst = BSR_GMUL;
                  next_s.cnt = {3'h0, nPar};
               end
            end
            BSR_GMUL: begin
               next_s.gen = genStep;
               next_s.root = rootNext;
               next_s.cnt = 8'(s.cnt - 8'h01);
               if (s.cnt == 8'h01) begin
                  next_s.gst = BSR_GIDLE;
               end
            end
            default: begin
               next_s.gst = BSR_GIDLE;
            end
         endcase
      end
      // Division register: clear wins, then a new byte, then unloading.
      if (clear) begin
         next_s.par = '0;
      end else if (feed) begin
         next_s.par = parStep;
      end else if (shiftOut) begin
         next_s.par = {s.par[18:0], 8'h00};
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s <= '0;
      end else if (ce) begin
         s <= next_s;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   pow_start_a: assert property ((rebuild && ce && !polySel)
      |=> s.gst == BSR_GPOW && s.cnt == 8'h78 && s.root == 8'h01)
      else $error("root power not started at 120");
   build_end_a: assert property ((s.gst == BSR_GMUL && s.cnt == 8'h01
      && ce && !rebuild) |=> s.gst == BSR_GIDLE)
      else $error("generator build did not end");
   par_clear_a: assert property ((clear && ce) |=> s.par == '0)
      else $error("parity not cleared");
endmodule

// *** sim/bsr_source.sv ***
// Model of the user logic that feeds serial bits to the encoder.
// Assumes one ref_clk domain; the bit clock falls every second cycle.
`timescale 1ns/1ps
module bsr_source (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rst,
   // Control from the bench.
   input wire logic go,
   input wire logic scrOn,
   input wire logic rsOn,
   input wire logic [23:0] pattern,
   // Toward the encoder.
   output logic bitClockFall,
   output logic txSerialIn,
   output logic dataAdvanceIn,
   output logic scrambleEnableIn,
   output logic rsEnableIn
);
   logic [23:0] bits;

   // Bits and enables change on the bit clock rising edge, the cycle after
   // a fall, so each bit stands a whole bit period before it is latched.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         bitClockFall <= 1'b0;
         txSerialIn <= 1'b0;
         dataAdvanceIn <= 1'b0;
         scrambleEnableIn <= 1'b0;
         rsEnableIn <= 1'b0;
         bits <= 24'h000000;
      end else begin
         bitClockFall <= ~bitClockFall;
         if (!go) begin
            // Idle line toggles so a stale bit is never mistaken for data.
            txSerialIn <= ~txSerialIn;
            dataAdvanceIn <= 1'b0;
            scrambleEnableIn <= 1'b0;
            rsEnableIn <= 1'b0;
            bits <= pattern;
         end else if (bitClockFall) begin
            txSerialIn <= bits[23];
            bits <= {bits[22:0], bits[23]};
            dataAdvanceIn <= 1'b1;
            scrambleEnableIn <= scrOn;
            rsEnableIn <= rsOn;
         end
      end
   end
endmodule

// *** sim/burst_scrambler_rs_encoder_tb.sv ***
// Self-checking bench for the burst scrambler and parity encoder.
// Assumes the design files and the data source model compile first.
`timescale 1ns/1ps
`include "bsr_params.svh"
module burst_scrambler_rs_encoder_tb;
   logic ref_clk = 1'b0, rst = 1'b1, go = 1'b0, scrOn = 1'b0, rsOn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
   logic [9:0] paddr = 10'h000;
   logic [31:0] pwdata = 32'h00000000, prdata, rd;
   logic [23:0] pattern = 24'h000000;
   logic bitClockFall, txSerialIn, dataAdvanceIn, scrambleEnableIn;
   logic rsEnableIn, txSerialOut, txOutValid, parityInsertFlag;
   logic pready, pslverr;
   logic [1:0] outQ[$];
   int failures = 0, checks = 0, cycles = 0;

   bsr_source u_src (.ref_clk(ref_clk), .rst(rst), .go(go), .scrOn(scrOn),
      .rsOn(rsOn), .pattern(pattern), .bitClockFall(bitClockFall),
      .txSerialIn(txSerialIn), .dataAdvanceIn(dataAdvanceIn),
      .scrambleEnableIn(scrambleEnableIn), .rsEnableIn(rsEnableIn));
   bsr_encoder u_dut (.ref_clk(ref_clk), .rst(rst), .clkEn(1'b1),
      .bitClockFall(bitClockFall), .txSerialIn(txSerialIn),
      .dataAdvanceIn(dataAdvanceIn), .scrambleEnableIn(scrambleEnableIn),
      .rsEnableIn(rsEnableIn), .txSerialOut(txSerialOut),
      .txOutValid(txOutValid), .parityInsertFlag(parityInsertFlag),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   initial begin
      forever #25 ref_clk = ~ref_clk;
   end

   // Collect each output bit with its flag; a hang ends the run here.
   always @(posedge ref_clk) begin
      cycles++;
      if (txOutValid === 1'b1) outQ.push_back({parityInsertFlag, txSerialOut});
      if (cycles == 20000) begin
         failures++;
         end_of_test();
      end
   end

   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One APB transfer; the request holds until pready is seen high.
   task apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h000000, wd};
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Run the source until n bits have come out, then stop it.
   task stream(input int n, input logic [23:0] pat, input logic s, r);
      outQ.delete();
      pattern <= pat;
      scrOn <= s;
      rsOn <= r;
      // Let the source load the new pattern while still idle.
      @(posedge ref_clk);
      go <= 1'b1;
      while (outQ.size() < n) @(posedge ref_clk);
      go <= 1'b0;
      repeat (6) @(posedge ref_clk);
   endtask

   // Reset values, read-back of seed and taps, then the scrambler setup.
   task reg_test;
      logic [7:0] idx;
      for (int i = 0; i < 6; i++) begin
         idx = `BSR_IDX_SEED_LO + 8'(i);
         apb(1'b0, idx, 8'h00);
         chk(rd, 32'h00000000);
         apb(1'b1, idx, 8'h5A + 8'(i));
         apb(1'b0, idx, 8'h00);
         chk(rd, 32'h0000005A + i);
         apb(1'b1, idx, (i == 0) ? 8'hA9 : (i == 4) ? 8'h60 : 8'h00);
      end
      apb(1'b0, `BSR_IDX_CTRL, 8'h00);
      chk(rd, 32'h00000001);
      apb(1'b0, `BSR_IDX_KLEN, 8'h00);
      chk(rd, 32'h00000001);
      apb(1'b0, 8'h38, 8'h00);
      chk({31'h00000000, err}, 32'h00000001);
      chk(rd, 32'h00000000);
   endtask

   // Scrambler off, frame sync and self sync against a reference model.
   task scr_run(input logic on, input logic self);
      logic [23:0] st;
      logic fb, o;
      apb(1'b1, `BSR_IDX_CTRL, {3'b000, self, 4'h1});
      stream(24, 24'hC3A55A, on, 1'b0);
      st = 24'h0000A9;
      for (int i = 0; i < 24; i++) begin
         fb = on & (^(st & 24'h006000));
         o = pattern[23 - i] ^ fb;
         chk(outQ[i][0], o);
         st = {st[22:0], self ? o : fb};
      end
   endtask

   // K=1, T=1, second field polynomial: byte 80 gives parity 07 87.
   task rs_run(input logic [7:0] ord);
      logic [23:0] exp;
      apb(1'b1, `BSR_IDX_ORDER, ord);
      apb(1'b1, `BSR_IDX_KLEN, 8'h01);
      apb(1'b1, `BSR_IDX_CTRL, 8'h81);
      do apb(1'b0, `BSR_IDX_STAT, 8'h00); while (rd[1] !== 1'b0);
      // Ones after the data byte must be ignored while parity goes out.
      stream(24, {ord[4] ? 8'h01 : 8'h80, 16'hFFFF}, 1'b0, 1'b1);
      exp = {pattern[23:16], ord[5] ? 16'hE0E1 : 16'h0787};
      for (int i = 0; i < 24; i++) begin
         chk(outQ[i], {i >= 8, exp[23 - i]});
      end
   endtask

   task end_of_test;
      if (failures == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   initial begin
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      reg_test();
      scr_run(1'b0, 1'b0);
      scr_run(1'b1, 1'b0);
      scr_run(1'b1, 1'b1);
      rs_run(8'h00);
      rs_run(8'h30);
      end_of_test();
   end
endmodule
